// ### ubb_regs.svh
`ifndef UBB_REGS_SVH
`define UBB_REGS_SVH

// Record codes leading each five-byte board bus record
`define UBB_CODE_ADDR        8'h00
`define UBB_CODE_DATA        8'h01
// Record layout: one code byte, then four payload bytes
`define UBB_REC_LAST         3'h4
`define UBB_WORD_BYTES       2'h3
// Vendor request codes
`define UBB_VR_NULL_A        8'hC0
`define UBB_VR_TWOWIRE_SLOW  8'hAA
`define UBB_VR_TWOWIRE_FAST  8'hAB
`define UBB_VR_RERUN_BOOT    8'hAD
`define UBB_VR_FW_ERASE      8'hAE
`define UBB_VR_FW_BYTE       8'hB0
`define UBB_VR_FW_SECTOR     8'hB1
`define UBB_VR_FW_VERSION    8'hB2
`define UBB_VR_TARGET_QUERY  8'hB4
`define UBB_VR_NULL_B        8'hB6
`define UBB_VR_RD_BUF_SIZE   8'hBB
`define UBB_VR_SELECT        8'hBD
`define UBB_VR_FINISH        8'hBE
// Answer bytes for status requests
`define UBB_RESP_YES         8'h01
`define UBB_RESP_NO          8'h00
// Reset values
`define UBB_ADDR_RESET       32'h0000_0000
// Timing: clock period and least width of the program-clear pulse
`define UBB_CLK_NS           50
`define UBB_CLEAR_NS         500
`define UBB_CLEAR_CYC        ((`UBB_CLEAR_NS + `UBB_CLK_NS - 1) / `UBB_CLK_NS)

`endif

// ### ubb_pkg.sv
package ubb_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		UBB_IDLE  = 4'b0001,
		UBB_WRITE = 4'b0010,
		UBB_READ  = 4'b0100,
		UBB_SEND  = 4'b1000
	} ubb_fsm_type;

endpackage

// ### ubb_bridge.sv
// Notes on behaviour
// - Record starts with code: 00 address, 01 data
// - Address record loads transaction address register
// - Payload bytes travel least significant first
// - Data record writes word, then address increments
// - Read returns words, address advances by count/4
// - One address pointer for reads and writes
// - Select pulses clear line, routes config bus
// - Selected target turns bulk into config stream
// - Each config byte driven, strobe pulsed once
// - Byte bits map straight, no reversal
// - Finish request deselects, reports done status
// - Without hold, targets start as stream directs
// - Rerun-boot request restarts power-on configuration
// - Requests choose slow or fast two-wire rate
// - Firmware erase, byte write, sector, version
// - Query reports whether selected target configured
// - Two null requests accepted, do nothing
// - Bridge alone initiates board bus transactions
// - Setting holds targets until all configured
// - Error code captured after each transaction
`timescale 1ns/1ps
`include "ubb_regs.svh"

module ubb_bridge
	import ubb_pkg::*;
#(
	parameter int NT = 16,	// Number of target FPGAs
	parameter int RW = 16	// Width of bulk read byte count
) (
	input  wire logic          ref_clk_i,
	input  wire logic          srst_i,
	// Vendor requests
	input  wire logic          vreq_valid_i,
	input  wire logic [7:0]    vreq_code_i,
	input  wire logic [15:0]   vreq_value_i,
	output logic               vreq_ready_o,
	output logic               vreq_ack_o,
	output logic [7:0]         vreq_resp_o,
	// Bulk write byte stream
	input  wire logic          bulk_valid_i,
	input  wire logic [7:0]    bulk_data_i,
	output logic               bulk_ready_o,
	// Bulk read request and returned bytes
	input  wire logic          rd_req_valid_i,
	input  wire logic [RW-1:0] rd_req_size_i,
	output logic               rd_req_ready_o,
	output logic               rd_byte_valid_o,
	output logic [7:0]         rd_byte_o,
	output logic               rd_done_o,
	// Board bus master
	output logic               bb_req_o,
	output logic               bb_we_o,
	output logic [31:0]        bb_addr_o,
	output logic [31:0]        bb_wdata_o,
	input  wire logic          bb_ack_i,
	input  wire logic [31:0]   bb_rdata_i,
	input  wire logic [7:0]    bb_err_i,
	output logic [7:0]         bb_error_o,
	// Configuration bus
	output logic [NT-1:0]      config_clear_line_o,
	output logic [NT-1:0]      cfg_select_o,
	output logic [7:0]         cfg_data_o,
	output logic               config_byte_strobe_o,
	input  wire logic [NT-1:0] cfg_done_i,
	input  wire logic          hold_until_all_setting_i,
	output logic               hold_until_all_configured_o,
	// Board control strobes and levels
	output logic               rerun_boot_o,
	output logic               twowire_fast_o,
	output logic               firmware_erase_o,
	output logic               firmware_byte_write_o,
	output logic               firmware_sector_erase_o,
	output logic               firmware_version_o,
	output logic [15:0]        read_buffer_size_o
);

	// All state of the bridge
	typedef struct packed {
		ubb_fsm_type   fsm;        // Sequencer state
		logic [31:0]   addr;       // Shared transaction address
		logic [2:0]    rec_cnt;    // Byte position in a record
		logic [7:0]    rec_code;   // Code byte of current record
		logic [31:0]   rec_word;   // Payload being assembled
		logic          bb_req;     // Board bus request
		logic          bb_we;      // Board bus write flag
		logic [31:0]   bb_addr;    // Board bus address
		logic [31:0]   bb_wdata;   // Board bus write data
		logic [7:0]    bb_error;   // Last captured error code
		logic [31:0]   rd_word;    // Word being sent to host
		logic [1:0]    rd_idx;     // Byte index within rd_word
		logic [RW-3:0] words_left; // Words still to read
		logic          rd_valid;   // Read byte valid
		logic [7:0]    rd_byte;    // Read byte
		logic          rd_done;    // Read finished pulse
		logic          rd_ready;   // Read request ready
		logic          bulk_ready; // Bulk byte ready
		logic          vreq_ready; // Vendor request ready
		logic          vreq_ack;   // Vendor request answer pulse
		logic [7:0]    vreq_resp;  // Vendor request answer
		logic [NT-1:0] target;     // Selected target, one-hot
		logic          cfg_mode;   // Bulk carries config stream
		logic [NT-1:0] clear;      // Program-clear lines
		logic [7:0]    clear_cnt;  // Clear pulse cycles left
		logic [7:0]    cfg_data;   // Config data bus
		logic          cfg_strobe; // Config byte strobe
		logic          hold;       // Hold targets in reset
		logic          rerun;      // Rerun boot pulse
		logic          tw_fast;    // Two-wire fast rate
		logic          fw_erase;   // Firmware erase pulse
		logic          fw_byte;    // Firmware byte write pulse
		logic          fw_sector;  // Firmware sector erase pulse
		logic          fw_version; // Firmware version pulse
		logic [15:0]   rd_buf;     // Read buffer size setting
	} ubb_state_type;

	localparam logic [7:0] CLEAR_CYC = 8'(`UBB_CLEAR_CYC);

	ubb_state_type s;       // Registered state
	ubb_state_type next_s;  // Next state
	logic          bulk_take;  // Bulk byte taken this cycle
	logic          vreq_take;  // Vendor request taken this cycle
	logic          rd_take;    // Read request taken this cycle
	logic [7:0]    vbyte;      // Low byte of request value

	// Picks byte n of a word, least significant first
	function automatic logic [7:0] word_byte(input logic [31:0] w,
		input logic [1:0] n);
		word_byte = w[8*n +: 8];
	endfunction
	// Is the currently selected target configured
	function automatic logic [7:0] done_answer(input logic [NT-1:0] t,
		input logic [NT-1:0] d);
		done_answer = (|(t & d)) ? `UBB_RESP_YES : `UBB_RESP_NO;
	endfunction
	assign bulk_take = bulk_valid_i && s.bulk_ready;
	assign vreq_take = vreq_valid_i && s.vreq_ready;
	assign rd_take   = rd_req_valid_i && s.rd_ready;
	assign vbyte     = vreq_value_i[7:0];

	// Next-state logic
	always_comb begin
		next_s = s;
		next_s.vreq_ack   = 1'b0;
		next_s.rd_done    = 1'b0;
		next_s.rd_valid   = 1'b0;
		next_s.cfg_strobe = 1'b0;
		next_s.rerun      = 1'b0;
		next_s.fw_erase   = 1'b0;
		next_s.fw_byte    = 1'b0;
		next_s.fw_sector  = 1'b0;
		next_s.fw_version = 1'b0;
		// Hold targets only while the setting asks and some are unready
		next_s.hold = hold_until_all_setting_i && !(&cfg_done_i);
		// Program-clear pulse timing
		if (s.clear_cnt != 8'h00) begin
			next_s.clear_cnt = s.clear_cnt - 8'h01;
		end else begin
			next_s.clear = '0;
		end
		unique case (s.fsm)
			UBB_IDLE: begin
				if (bulk_take && s.cfg_mode) begin
					// Stream byte to the target, bits in place
					next_s.cfg_data   = bulk_data_i;
					next_s.cfg_strobe = 1'b1;
				end else if (bulk_take) begin
					next_s.rec_cnt = s.rec_cnt + 3'h1;
					if (s.rec_cnt == 3'h0) begin
						next_s.rec_code = bulk_data_i;
					end else begin
						// Shift in from the top: first byte lands lowest
						next_s.rec_word = {bulk_data_i, s.rec_word[31:8]};
					end
					if (s.rec_cnt == `UBB_REC_LAST) begin
						next_s.rec_cnt = 3'h0;
						if (s.rec_code == `UBB_CODE_ADDR) begin
							next_s.addr = {bulk_data_i, s.rec_word[31:8]};
						end else if (s.rec_code == `UBB_CODE_DATA) begin
							// Bridge starts the write itself
							next_s.fsm      = UBB_WRITE;
							next_s.bb_req   = 1'b1;
							next_s.bb_we    = 1'b1;
							next_s.bb_addr  = s.addr;
							next_s.bb_wdata = {bulk_data_i, s.rec_word[31:8]};
						end
					end
				end else if (rd_take) begin
					next_s.words_left = rd_req_size_i[RW-1:2];
					if (rd_req_size_i[RW-1:2] == '0) begin
						next_s.rd_done = 1'b1;
					end else begin
						next_s.fsm     = UBB_READ;
						next_s.bb_req  = 1'b1;
						next_s.bb_we   = 1'b0;
						next_s.bb_addr = s.addr;
					end
				end else if (vreq_take) begin
					next_s.vreq_ack  = 1'b1;
					next_s.vreq_resp = `UBB_RESP_NO;
					unique case (vreq_code_i)
						`UBB_VR_SELECT: begin
							// One-based target number
							if (vbyte != 8'h00 && 32'(vbyte) <= NT) begin
								next_s.target    = NT'(1) << (vbyte - 8'h01);
								next_s.clear     = NT'(1) << (vbyte - 8'h01);
								next_s.clear_cnt = CLEAR_CYC;
								next_s.cfg_mode  = 1'b1;
								next_s.rec_cnt   = 3'h0;
							end
						end
						`UBB_VR_FINISH: begin
							next_s.vreq_resp = done_answer(s.target, cfg_done_i);
							next_s.target    = '0;
							next_s.cfg_mode  = 1'b0;
						end
						`UBB_VR_TARGET_QUERY:
							next_s.vreq_resp = done_answer(s.target, cfg_done_i);
						`UBB_VR_RERUN_BOOT:   next_s.rerun      = 1'b1;
						`UBB_VR_TWOWIRE_SLOW: next_s.tw_fast    = 1'b0;
						`UBB_VR_TWOWIRE_FAST: next_s.tw_fast    = 1'b1;
						`UBB_VR_FW_ERASE:     next_s.fw_erase   = 1'b1;
						`UBB_VR_FW_BYTE:      next_s.fw_byte    = 1'b1;
						`UBB_VR_FW_SECTOR:    next_s.fw_sector  = 1'b1;
						`UBB_VR_FW_VERSION:   next_s.fw_version = 1'b1;
						`UBB_VR_RD_BUF_SIZE:  next_s.rd_buf     = vreq_value_i;
						// Null requests: answered, nothing else
						default: next_s.vreq_resp = `UBB_RESP_NO;
					endcase
				end
			end
			UBB_WRITE: begin
				if (bb_ack_i) begin
					// Wraps to zero past the top
					next_s.addr     = s.addr + 32'h1;
					next_s.bb_error = bb_err_i;
					next_s.bb_req   = 1'b0;
					next_s.fsm      = UBB_IDLE;
				end
			end
			UBB_READ: begin
				if (bb_ack_i) begin
					next_s.bb_error = bb_err_i;
					next_s.bb_req   = 1'b0;
					next_s.rd_word  = bb_rdata_i;
					next_s.rd_idx   = 2'h0;
					next_s.fsm      = UBB_SEND;
				end
			end
			UBB_SEND: begin
				// Bytes leave least significant first
				next_s.rd_valid = 1'b1;
				next_s.rd_byte  = word_byte(s.rd_word, s.rd_idx);
				next_s.rd_idx   = s.rd_idx + 2'h1;
				if (s.rd_idx == `UBB_WORD_BYTES) begin
					// Per-word step sums to count/4 by the end
					next_s.addr       = s.addr + 32'h1;
					next_s.words_left = s.words_left - 1'b1;
					if (s.words_left == 1) begin
						next_s.rd_done = 1'b1;
						next_s.fsm     = UBB_IDLE;
					end else begin
						next_s.fsm     = UBB_READ;
						next_s.bb_req  = 1'b1;
						next_s.bb_addr = s.addr + 32'h1;
					end
				end
			end
		endcase
		// Readiness: bulk before reads before vendor requests
		next_s.bulk_ready = (next_s.fsm == UBB_IDLE) && !next_s.cfg_strobe
			&& !(bulk_take && s.rec_cnt == `UBB_REC_LAST && !s.cfg_mode);
		next_s.rd_ready   = (next_s.fsm == UBB_IDLE) && !next_s.cfg_mode
			&& !bulk_valid_i && !next_s.rd_done;
		next_s.vreq_ready = (next_s.fsm == UBB_IDLE) && !bulk_valid_i
			&& !rd_req_valid_i && !next_s.vreq_ack;
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s          <= '0;
			s.fsm      <= UBB_IDLE;
			s.addr     <= `UBB_ADDR_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state
	assign vreq_ready_o                = s.vreq_ready;
	assign vreq_ack_o                  = s.vreq_ack;
	assign vreq_resp_o                 = s.vreq_resp;
	assign bulk_ready_o                = s.bulk_ready;
	assign rd_req_ready_o              = s.rd_ready;
	assign rd_byte_valid_o             = s.rd_valid;
	assign rd_byte_o                   = s.rd_byte;
	assign rd_done_o                   = s.rd_done;
	assign bb_req_o                    = s.bb_req;
	assign bb_we_o                     = s.bb_we;
	assign bb_addr_o                   = s.bb_addr;
	assign bb_wdata_o                  = s.bb_wdata;
	assign bb_error_o                  = s.bb_error;
	assign config_clear_line_o         = s.clear;
	assign cfg_select_o                = s.target;
	assign cfg_data_o                  = s.cfg_data;
	assign config_byte_strobe_o        = s.cfg_strobe;
	assign hold_until_all_configured_o = s.hold;
	assign rerun_boot_o                = s.rerun;
	assign twowire_fast_o              = s.tw_fast;
	assign firmware_erase_o            = s.fw_erase;
	assign firmware_byte_write_o       = s.fw_byte;
	assign firmware_sector_erase_o     = s.fw_sector;
	assign firmware_version_o          = s.fw_version;
	assign read_buffer_size_o          = s.rd_buf;

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_four_bytes;
		rd_byte_valid_o [*4];
	endsequence

	chk_addr_load: assert property (
		bulk_take && !s.cfg_mode && s.rec_cnt == `UBB_REC_LAST
		&& s.rec_code == `UBB_CODE_ADDR
		|=> s.addr == {$past(bulk_data_i), $past(s.rec_word[31:8])})
		else $error("address record not loaded");
	chk_write_step: assert property (
		s.fsm == UBB_WRITE && bb_ack_i
		|=> s.addr == $past(s.addr) + 32'h1 && !bb_req_o)
		else $error("address not stepped after write");
	chk_write_issue: assert property (
		bulk_take && !s.cfg_mode && s.rec_cnt == `UBB_REC_LAST
		&& s.rec_code == `UBB_CODE_DATA
		|=> bb_req_o && bb_we_o && bb_addr_o == $past(s.addr))
		else $error("data record did not start write");
	chk_cfg_byte: assert property (
		bulk_take && s.cfg_mode
		|=> config_byte_strobe_o && cfg_data_o == $past(bulk_data_i)
		##1 !config_byte_strobe_o)
		else $error("config byte not strobed once");
	chk_clear_pulse: assert property (
		vreq_take && vreq_code_i == `UBB_VR_SELECT && vbyte != 8'h00
		&& 32'(vbyte) <= NT
		|=> cfg_select_o == (NT'(1) << ($past(vbyte) - 8'h01))
		##0 (config_clear_line_o == cfg_select_o) [*8])
		else $error("clear pulse too short");
	chk_finish_mode: assert property (
		vreq_take && vreq_code_i == `UBB_VR_FINISH
		|=> vreq_ack_o && !s.cfg_mode && cfg_select_o == '0)
		else $error("finish request left target selected");
	// Word lands one cycle after ack, bytes follow a cycle later
	chk_read_word: assert property (
		s.fsm == UBB_READ && bb_ack_i
		|=> ##1 s_four_bytes ##0 rd_byte_o == $past(bb_rdata_i[31:24], 5))
		else $error("read word not returned in four bytes");
	chk_error_cap: assert property (
		bb_req_o && bb_ack_i |=> bb_error_o == $past(bb_err_i))
		else $error("error code not captured");
	chk_no_bus_cfg: assert property (
		s.cfg_mode |-> !bb_req_o)
		else $error("board bus used in config mode");

endmodule

// ### ubb_host_model.sv
`timescale 1ns/1ps

// Host program: drives requests at the falling edge, holds until taken
module ubb_host_model (
	input  wire logic        clk_i,
	input  wire logic        vreq_ready_i,
	input  wire logic        vreq_ack_i,
	input  wire logic [7:0]  vreq_resp_i,
	input  wire logic        bulk_ready_i,
	input  wire logic        rd_req_ready_i,
	output logic             vreq_valid_o = 1'b0,
	output logic [7:0]       vreq_code_o = 8'h00,
	output logic [15:0]      vreq_value_o = 16'h0000,
	output logic             bulk_valid_o = 1'b0,
	output logic [7:0]       bulk_data_o = 8'h00,
	output logic             rd_req_valid_o = 1'b0,
	output logic [15:0]      rd_req_size_o = 16'h0000,
	output logic [7:0]       resp_o = 8'h00,
	output logic             hang_o = 1'b0
);
	// Ready line of one interface: 0 vendor, 1 bulk, 2 read
	function automatic logic rdy_of(input int k);
		rdy_of = (k == 0) ? vreq_ready_i
			: (k == 1) ? bulk_ready_i : rd_req_ready_i;
	endfunction

	// Waits for the edge where that ready is sampled high, bounded
	task automatic wait_taken(input int k);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rdy_of(k) !== 1'b1 && n < 300);
		if (rdy_of(k) !== 1'b1) hang_o = 1'b1;
	endtask

	// Vendor request; value low byte names a target, one-based
	task automatic send_vreq(input logic [7:0] c, input logic [15:0] v);
		@(negedge clk_i);
		vreq_valid_o = 1'b1;
		vreq_code_o  = c;
		vreq_value_o = v;
		wait_taken(0);
		@(negedge clk_i);
		// Released lines show the inverse of the last value
		vreq_valid_o = 1'b0;
		vreq_code_o  = ~c;
		vreq_value_o = ~v;
		if (vreq_ack_i !== 1'b1) hang_o = 1'b1;
		else resp_o = vreq_resp_i;
	endtask

	// One bulk byte; callers send whole five-byte records or, in config mode, single stream bytes
	task automatic send_byte(input logic [7:0] b);
		@(negedge clk_i);
		bulk_valid_o = 1'b1;
		bulk_data_o  = b;
		wait_taken(1);
		@(negedge clk_i);
		bulk_valid_o = 1'b0;
		bulk_data_o  = ~b;
	endtask

	// Bulk read, size a multiple of four
	task automatic send_read(input logic [15:0] s);
		@(negedge clk_i);
		rd_req_valid_o = 1'b1;
		rd_req_size_o  = s;
		wait_taken(2);
		@(negedge clk_i);
		rd_req_valid_o = 1'b0;
		rd_req_size_o  = ~s;
	endtask
endmodule

// ### ubb_bridge_tb_top.sv
`timescale 1ns/1ps
`include "ubb_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module ubb_bridge_tb_top;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic vv, bv, rv, vrdy, ack, brdy, rrdy, rbv, rdone, hang;
	logic [7:0] vc, bd, resp, hresp, rbyte, cdata, berr;
	logic [15:0] vval, rsize, sel, clr, rbs;
	logic [31:0] baddr, bwdata;
	logic breq, bwe, stb, hold_o, fast;
	logic [4:0] pul;
	logic bb_ack_i = 1'b0;
	logic [31:0] bb_rdata_i = 32'h0;
	logic [7:0] bb_err_i = 8'h00;
	logic [15:0] cfg_done_i = 16'h0000;
	logic hold_set = 1'b0;
	logic [31:0] wa[$], wd[$];
	logic [7:0] rq[$], cq[$];
	int failures = 0, compares = 0, bcnt = 0, ndone = 0, clr_n = 0;
	int pc[5] = '{0, 0, 0, 0, 0};

	ubb_bridge uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.vreq_valid_i(vv), .vreq_code_i(vc), .vreq_value_i(vval),
		.vreq_ready_o(vrdy), .vreq_ack_o(ack), .vreq_resp_o(resp),
		.bulk_valid_i(bv), .bulk_data_i(bd), .bulk_ready_o(brdy),
		.rd_req_valid_i(rv), .rd_req_size_i(rsize),
		.rd_req_ready_o(rrdy), .rd_byte_valid_o(rbv),
		.rd_byte_o(rbyte), .rd_done_o(rdone), .bb_req_o(breq),
		.bb_we_o(bwe), .bb_addr_o(baddr), .bb_wdata_o(bwdata),
		.bb_ack_i(bb_ack_i), .bb_rdata_i(bb_rdata_i), .bb_err_i(bb_err_i),
		.bb_error_o(berr), .config_clear_line_o(clr),
		.cfg_select_o(sel), .cfg_data_o(cdata),
		.config_byte_strobe_o(stb), .cfg_done_i(cfg_done_i),
		.hold_until_all_setting_i(hold_set),
		.hold_until_all_configured_o(hold_o), .rerun_boot_o(pul[0]),
		.twowire_fast_o(fast), .firmware_erase_o(pul[1]),
		.firmware_byte_write_o(pul[2]),
		.firmware_sector_erase_o(pul[3]),
		.firmware_version_o(pul[4]), .read_buffer_size_o(rbs));

	ubb_host_model host (.clk_i(ref_clk_i), .vreq_ready_i(vrdy),
		.vreq_ack_i(ack), .vreq_resp_i(resp), .bulk_ready_i(brdy),
		.rd_req_ready_i(rrdy), .vreq_valid_o(vv), .vreq_code_o(vc),
		.vreq_value_o(vval), .bulk_valid_o(bv), .bulk_data_o(bd),
		.rd_req_valid_o(rv), .rd_req_size_o(rsize), .resp_o(hresp),
		.hang_o(hang));

	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// Board target: acks on the second cycle of a request
	always @(negedge ref_clk_i) begin
		if (breq === 1'b1 && !bb_ack_i && bcnt == 1) begin
			bcnt = 0;
			bb_ack_i <= 1'b1;
			bb_rdata_i <= ~baddr;
			bb_err_i <= baddr[7:0] ^ 8'h5A;
			if (bwe) begin
				wa.push_back(baddr);
				wd.push_back(bwdata);
			end
		end else begin
			bcnt = (breq === 1'b1 && !bb_ack_i) ? bcnt + 1 : 0;
			bb_ack_i <= 1'b0;
			bb_rdata_i <= ~bb_rdata_i;
		end
	end

	// Monitors of returned bytes, config bytes and strobes
	always @(posedge ref_clk_i) begin
		if (rbv === 1'b1) rq.push_back(rbyte);
		if (rdone === 1'b1) ndone++;
		if (stb === 1'b1) cq.push_back(cdata);
		if (clr === 16'h0002) clr_n++;
		for (int i = 0; i < 5; i++) if (pul[i] === 1'b1) pc[i]++;
	end

	always @(posedge hang) begin
		failures++;
		finish_test();
	end

	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic settle(input int k);
		repeat (k) @(negedge ref_clk_i);
	endtask

	// Bounded wait for board writes or read completions
	task automatic wait_for(input int rd, input int k);
		int n;
		n = 0;
		while ((rd ? ndone : wa.size()) < k && n < 500) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n >= 500) begin
			failures++;
			finish_test();
		end
	endtask

	// Record: code byte, then payload least significant byte first
	task automatic rec(input logic [7:0] c, input logic [31:0] w);
		host.send_byte(c);
		for (int i = 0; i < 4; i++) host.send_byte(w[8*i+:8]);
	endtask

	task automatic t_reset();
		`CHK("select", 16'h0000, sel)
		`CHK("fast", 1'b0, fast)
		rec(`UBB_CODE_DATA, 32'hCAFEF00D);
		wait_for(0, 1);
		`CHK("addr", `UBB_ADDR_RESET, wa[0])
		$display("test reset done");
	endtask

	task automatic t_write();
		wa.delete();
		wd.delete();
		rec(`UBB_CODE_ADDR, 32'hFFFFFFFE);
		rec(`UBB_CODE_DATA, 32'h11223344);
		rec(`UBB_CODE_DATA, 32'h55667788);
		rec(`UBB_CODE_DATA, 32'hA5A5A5A5);
		wait_for(0, 3);
		settle(2);
		`CHK("waddr0", 32'hFFFFFFFE, wa[0])
		`CHK("wdata0", 32'h11223344, wd[0])
		`CHK("waddr1", 32'hFFFFFFFF, wa[1])
		`CHK("wdata1", 32'h55667788, wd[1])
		`CHK("wrap", 32'h00000000, wa[2])
		`CHK("error", 8'h5A, berr)
		$display("test write done");
	endtask

	task automatic t_read();
		logic [31:0] w;
		wa.delete();
		rq.delete();
		rec(`UBB_CODE_ADDR, 32'h00000100);
		host.send_read(16'h0008);
		wait_for(1, 1);
		`CHK("rbytes", 8, rq.size())
		for (int i = 0; i < 8; i++) begin
			w = ~(32'h100 + i / 4);
			`CHK("rbyte", w[8*(i%4)+:8], rq[i])
		end
		rec(`UBB_CODE_DATA, 32'h00000001);
		wait_for(0, 1);
		`CHK("shared", 32'h00000102, wa[0])
		$display("test read done");
	endtask

	task automatic t_config();
		logic [7:0] b[5] = '{8'hA5, 8'h3C, 8'h81, 8'h01, 8'h80};
		wa.delete();
		wd.delete();
		cq.delete();
		host.send_vreq(`UBB_VR_SELECT, 16'h0002);
		`CHK("select", 16'h0002, sel)
		settle(14);
		`CHK("clear", 1'b1, clr_n >= 10)
		for (int i = 0; i < 5; i++) host.send_byte(b[i]);
		settle(3);
		`CHK("strobes", 5, cq.size())
		for (int i = 0; i < 5; i++) `CHK("cfgbyte", b[i], cq[i])
		`CHK("nobus", 0, wa.size())
		cfg_done_i = 16'h0002;
		host.send_vreq(`UBB_VR_TARGET_QUERY, 16'h0000);
		`CHK("query", `UBB_RESP_YES, hresp)
		host.send_vreq(`UBB_VR_FINISH, 16'h0000);
		`CHK("done", `UBB_RESP_YES, hresp)
		`CHK("desel", 16'h0000, sel)
		host.send_vreq(`UBB_VR_NULL_A, 16'h0000);
		`CHK("nullans", 8'h00, hresp)
		rec(`UBB_CODE_DATA, 32'h0BADF00D);
		wait_for(0, 1);
		`CHK("boardmode", 32'h0BADF00D, wd[0])
		$display("test config done");
	endtask

	task automatic t_vendor();
		logic [7:0] c[5] = '{`UBB_VR_RERUN_BOOT, `UBB_VR_FW_ERASE,
			`UBB_VR_FW_BYTE, `UBB_VR_FW_SECTOR, `UBB_VR_FW_VERSION};
		int s;
		int p;
		for (int i = 0; i < 5; i++) begin
			s = pc[0] + pc[1] + pc[2] + pc[3] + pc[4];
			p = pc[i];
			host.send_vreq(c[i], 16'h0000);
			settle(2);
			`CHK("pulse", p + 1, pc[i])
			`CHK("total", s + 1, pc[0]+pc[1]+pc[2]+pc[3]+pc[4])
		end
		host.send_vreq(`UBB_VR_TWOWIRE_FAST, 16'h0000);
		`CHK("fast", 1'b1, fast)
		host.send_vreq(`UBB_VR_NULL_A, 16'h0000);
		host.send_vreq(`UBB_VR_NULL_B, 16'h0000);
		`CHK("nullresp", 8'h00, hresp)
		`CHK("nullfast", 1'b1, fast)
		host.send_vreq(`UBB_VR_TWOWIRE_SLOW, 16'h0000);
		`CHK("slow", 1'b0, fast)
		host.send_vreq(`UBB_VR_RD_BUF_SIZE, 16'h0040);
		`CHK("bufsize", 16'h0040, rbs)
		$display("test vendor done");
	endtask

	task automatic t_hold();
		hold_set = 1'b1;
		cfg_done_i = 16'h0000;
		settle(3);
		`CHK("hold", 1'b1, hold_o)
		cfg_done_i = 16'hFFFF;
		settle(3);
		`CHK("release", 1'b0, hold_o)
		hold_set = 1'b0;
		$display("test hold done");
	endtask

	initial begin
		repeat (8) @(negedge ref_clk_i);
		srst_i = 1'b0;
		settle(2);
		t_reset();
		t_write();
		t_read();
		t_config();
		t_vendor();
		t_hold();
		finish_test();
	end
endmodule
